// ### updown_counter_pkg.sv
package updown_counter_pkg;

  localparam int unsigned  CNT_W       = 4;
  localparam logic [3:0]   CNT_RESET   = 4'h0;
  localparam logic [3:0]   CNT_ZERO    = 4'h0;
  localparam logic [3:0]   DEC_MAX     = 4'h9;
  localparam logic [3:0]   BIN_MAX     = 4'hF;
  localparam logic         TC_IDLE     = 1'b1;
  localparam int unsigned  SYNC_STAGES = 2;

endpackage : updown_counter_pkg

// ### updown_sync.sv
`timescale 1ns/1ns
// ****************************************
// Two flip-flop synchroniser per bit
// ****************************************
module updown_sync #(
  parameter int unsigned W        = 1,
  parameter logic [W-1:0] INIT    = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      dout   <= INIT;
    end else if (ce) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : updown_sync

// ### updown_counter_bcd_binary.sv
`timescale 1ns/1ns
// ****************************************
// Four-bit up/down counter, decade or binary
// ****************************************
// Every pin is sampled on core_clk through two flops, so each pin change
// reaches the outputs three enabled edges later. Clock phases on the count
// pins must therefore last at least one core_clk cycle.
module updown_counter_bcd_binary #(
  parameter bit DECADE = 1'b1
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       up_count_clock,
  input  wire logic       down_count_clock,
  input  wire logic       master_clear,
  input  wire logic       parallel_preload_n,
  input  wire logic [3:0] preset_data_inputs,
  output logic      [3:0] counter_outputs,
  output logic            carry_out_n,
  output logic            borrow_out_n
);

  // ****************************************
  // Reset release
  // ****************************************
  // Reset takes hold at once and lets go only after two clean edges
  logic [1:0] rst_sync_q;
  logic       rst_int_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_q[1];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // All pins share one two-stage synchroniser; its reset levels are the
  // idle pin levels, so no false edge or load follows reset
  logic [7:0] pins_raw;
  logic [7:0] pins_s;

  assign pins_raw = {
    up_count_clock,
    down_count_clock,
    master_clear,
    parallel_preload_n,
    preset_data_inputs
  };

  updown_sync #(
    .W    (8),
    .INIT (8'hD0)
  ) u_sync (
    .clk   (core_clk),
    .rst_n (rst_int_n),
    .ce    (clk_en),
    .din   (pins_raw),
    .dout  (pins_s)
  );

  wire       up_s      = pins_s[7];
  wire       dn_s      = pins_s[6];
  wire       clear_s   = pins_s[5];
  wire       load_n_s  = pins_s[4];
  wire [3:0] data_s    = pins_s[3:0];

  // ****************************************
  // Edge detection
  // ****************************************
  logic up_prev_q;
  logic dn_prev_q;

  // Previous levels keep tracking during clear and load, so a clock held low
  // through them still yields a rise afterwards
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      up_prev_q <= 1'b1;
      dn_prev_q <= 1'b1;
    end else if (clk_en) begin
      up_prev_q <= up_s;
      dn_prev_q <= dn_s;
    end
  end

  wire up_rise = up_s & ~up_prev_q;
  wire dn_rise = dn_s & ~dn_prev_q;

  // ****************************************
  // Common count lines
  // ****************************************
  // A rise counts only while the other clock is high
  wire count_up   = up_rise & dn_s;
  wire count_down = dn_rise & up_s;

  // ****************************************
  // Mode decode
  // ****************************************
  // Clear beats load, load beats counting
  wire mode_clear = clear_s;
  wire mode_load  = ~clear_s & ~load_n_s;
  wire mode_count = ~clear_s & load_n_s;
  wire step_up    = mode_count & count_up;
  wire step_down  = mode_count & count_down & ~count_up;
  wire step_any   = step_up | step_down;

  // ****************************************
  // Count limits
  // ****************************************
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  wire [3:0] cnt_max  = DECADE ? updown_counter_pkg::DEC_MAX : updown_counter_pkg::BIN_MAX;
  wire       at_max   = (cnt_q == cnt_max);
  wire       at_zero  = (cnt_q == updown_counter_pkg::CNT_ZERO);
  // Decade counts above nine step back toward the legal range
  wire       over_max = DECADE && (cnt_q > updown_counter_pkg::DEC_MAX);

  // ****************************************
  // Up path
  // ****************************************
  wire       wrap_up  = at_max | over_max;
  wire [3:0] plus_one = cnt_q + 4'h1;
  wire [3:0] inc_val  = wrap_up ? updown_counter_pkg::CNT_ZERO : plus_one;

  // ****************************************
  // Down path
  // ****************************************
  wire       wrap_down = at_zero;
  wire [3:0] minus_one = cnt_q - 4'h1;
  wire [3:0] dec_val   = wrap_down ? cnt_max : minus_one;

  // ****************************************
  // Next count selection
  // ****************************************
  wire [3:0] step_val = step_up ? inc_val : dec_val;
  wire [3:0] hold_val = step_any ? step_val : cnt_q;
  wire [3:0] load_val = mode_load ? data_s : hold_val;

  assign cnt_d = mode_clear
               ? updown_counter_pkg::CNT_RESET
               : load_val;

  // ****************************************
  // Count register
  // ****************************************
  // Every stage toggles from the one shared next value, so all bits
  // change on the same core_clk edge and nothing ripples
  logic [3:0] stage_toggle;

  genvar bit_i;

  generate
    for (bit_i = 0; bit_i < 4; bit_i++) begin : g_stage
      assign stage_toggle[bit_i] = cnt_d[bit_i] ^ cnt_q[bit_i];

      always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
          cnt_q[bit_i] <= updown_counter_pkg::CNT_RESET[bit_i];
        end else if (clk_en && stage_toggle[bit_i]) begin
          cnt_q[bit_i] <= ~cnt_q[bit_i];
        end
      end
    end
  endgenerate

  // ****************************************
  // Terminal detection
  // ****************************************
  // Terminal flags use the count being stored, so a load or clear ends them
  wire at_max_d  = (cnt_d == cnt_max);
  wire at_zero_d = (cnt_d == updown_counter_pkg::CNT_ZERO);

  // ****************************************
  // Clock levels
  // ****************************************
  wire up_low = ~up_s;
  wire dn_low = ~dn_s;

  // ****************************************
  // Carry and borrow
  // ****************************************
  // The outputs repeat the low phase of the count clock at terminal count
  logic carry_q;
  logic borrow_q;

  wire carry_hit  = at_max_d & up_low & mode_count;
  wire borrow_hit = at_zero_d & dn_low & mode_count;
  wire carry_d    = carry_hit
                  ? ~updown_counter_pkg::TC_IDLE
                  : updown_counter_pkg::TC_IDLE;
  wire borrow_d   = borrow_hit
                  ? ~updown_counter_pkg::TC_IDLE
                  : updown_counter_pkg::TC_IDLE;

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      carry_q  <= updown_counter_pkg::TC_IDLE;
      borrow_q <= updown_counter_pkg::TC_IDLE;
    end else if (clk_en) begin
      carry_q  <= carry_d;
      borrow_q <= borrow_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Carry and borrow can clock the next stage directly, at three
  // core_clk cycles of added latency per stage
  assign counter_outputs = cnt_q;
  assign carry_out_n     = carry_q;
  assign borrow_out_n    = borrow_q;

endmodule : updown_counter_bcd_binary

// ### updown_monitor.sv
`timescale 1ns/1ns
// ****
// Port checks
// ****
module updown_monitor #(parameter bit DECADE = 1'b1) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic up_count_clock,
  input wire logic down_count_clock,
  input wire logic master_clear,
  input wire logic parallel_preload_n,
  input wire logic [3:0] preset_data_inputs,
  input wire logic [3:0] counter_outputs,
  input wire logic carry_out_n,
  input wire logic borrow_out_n
);
  localparam logic [3:0] MX = DECADE ? updown_counter_pkg::DEC_MAX : updown_counter_pkg::BIN_MAX;
  wire run = clk_en && !master_clear && parallel_preload_n;
  wire ld = clk_en && !master_clear && !parallel_preload_n;
  wire [3:0] cnt = counter_outputs;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_up;
    ($rose(up_count_clock) && down_count_clock && run) ##1 run[*3];
  endsequence
  sequence s_dn;
    ($rose(down_count_clock) && up_count_clock && run) ##1 run[*3];
  endsequence
  clear_wins_a: assert property ((master_clear && clk_en)[*5] |-> cnt == 4'h0)
    else $error("count not cleared");
  load_copy_a: assert property ((ld && $stable(preset_data_inputs))[*5] |-> cnt == preset_data_inputs)
    else $error("preset not loaded");
  count_up_a: assert property (s_up |-> cnt == ($past(cnt) >= MX ? 4'h0 : $past(cnt) + 4'h1))
    else $error("bad up step");
  count_down_a: assert property (s_dn |-> cnt == ($past(cnt) == 4'h0 ? MX : $past(cnt) - 4'h1))
    else $error("bad down step");
  carry_low_a: assert property (($fell(up_count_clock) && cnt == MX && run) ##1 (run && !up_count_clock)[*3]
    |-> !carry_out_n) else $error("carry missing");
  borrow_low_a: assert property (($fell(down_count_clock) && cnt == 4'h0 && run) ##1 (run && !down_count_clock)[*3]
    |-> !borrow_out_n) else $error("borrow missing");
  carry_rest_a: assert property (cnt != MX |-> carry_out_n)
    else $error("carry not idle");
  borrow_rest_a: assert property (cnt != 4'h0 |-> borrow_out_n)
    else $error("borrow not idle");
endmodule : updown_monitor
bind updown_counter_bcd_binary updown_monitor #(.DECADE(DECADE)) mon (.core_clk, .rst_n, .clk_en,
  .up_count_clock, .down_count_clock, .master_clear, .parallel_preload_n, .preset_data_inputs,
  .counter_outputs, .carry_out_n, .borrow_out_n);

// ### count_clock_source.sv
`timescale 1ns/1ns
// ****
// Count clock source
// ****
module count_clock_source (
  input  wire logic       core_clk,
  input  wire logic [1:0] req,
  output logic            up_count_clock,
  output logic            down_count_clock
);
  logic [2:0] ph_q = 3'h0;
  logic [1:0] dir_q = 2'h0;
  wire low = ph_q != 3'h0;
  always @(posedge core_clk) begin
    if (req != 2'h0) begin
      dir_q <= req;
      ph_q <= 3'h4;
    end else if (low) begin
      ph_q <= ph_q - 3'h1;
    end
  end
  // Only the requested clock dips, the other stays high
  assign up_count_clock = !(low && dir_q[0]);
  assign down_count_clock = !(low && dir_q[1]);
endmodule : count_clock_source

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam logic [3:0] MX = updown_counter_pkg::DEC_MAX;
  logic core_clk, up_count_clock, down_count_clock, carry_out_n, borrow_out_n;
  logic rst_n = 1'b0, master_clear = 1'b0, parallel_preload_n = 1'b1;
  logic [3:0] preset_data_inputs = 4'h0, m = 4'h0, seen_q = 4'h0, counter_outputs, q[$];
  logic [1:0] req = 2'h0;
  logic [16:0] rnd = 17'h120BE;
  int failures, total_checks, cyc;
  updown_counter_bcd_binary #(.DECADE(1'b1)) dut (.core_clk, .rst_n, .clk_en(1'b1), .up_count_clock,
    .down_count_clock, .master_clear, .parallel_preload_n, .preset_data_inputs, .counter_outputs,
    .carry_out_n, .borrow_out_n);
  count_clock_source src (.core_clk, .req, .up_count_clock, .down_count_clock);
  task chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task complete_run;
    if (failures == 0 && total_checks != 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task pulse(input logic [1:0] d);
    logic [3:0] o;
    o = m;
    m = d[0] ? (o >= MX ? 4'h0 : o + 4'h1) : (o == 4'h0 ? MX : o - 4'h1);
    q.push_back(m);
    req <= d;
    @(posedge core_clk);
    req <= 2'h0;
    repeat (4) @(posedge core_clk);
    #1;
    chk({3'h0, carry_out_n}, {3'h0, !(d[0] && o == MX)});
    chk({3'h0, borrow_out_n}, {3'h0, !(d[1] && o == 4'h0)});
    repeat (6) @(posedge core_clk);
  endtask : pulse
  task preset(input logic [3:0] v, input logic c);
    master_clear <= c;
    parallel_preload_n <= 1'b0;
    preset_data_inputs <= v;
    if ((c ? 4'h0 : v) !== m) q.push_back(c ? 4'h0 : v);
    m = c ? 4'h0 : v;
    repeat (6) @(posedge core_clk);
    master_clear <= 1'b0;
    parallel_preload_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : preset
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  always @(negedge core_clk) begin
    if (counter_outputs !== seen_q) begin
      chk(counter_outputs, q.size() != 0 ? q.pop_front() : seen_q);
      seen_q <= counter_outputs;
    end
    cyc++;
    if (cyc == 3000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    preset(4'h7, 1'b0);
    repeat (12) pulse(2'h1);
    repeat (12) pulse(2'h2);
    preset(4'h5, 1'b1);
    for (int i = 0; i < 30; i++) begin
      rnd = lfsr(rnd);
      if (rnd[5:4] == 2'h0) preset(rnd[3:0], rnd[6]);
      else pulse({!rnd[0], rnd[0]});
    end
    repeat (4) @(posedge core_clk);
    complete_run();
  end
endmodule : tb_top
